/* File: core/ctt_pkg.sv */
// Package: register map, field layout and timing constants of the tick timer
package ctt_pkg;

    // -------------------------------------------------------------------
    // Register map (byte addresses; printed offsets not all multiples of four)
    // -------------------------------------------------------------------
    localparam logic [7:0]  IDX_CONTROL_STATUS = 8'h08;
    localparam logic [7:0]  IDX_COUNT_VALUE    = 8'h09;
    localparam logic [7:0]  IDX_WATCHDOG_SVC   = 8'h0a;
    localparam logic [7:0]  IDX_POWER_MODE     = 8'h0b;
    localparam logic [11:0] ADDR_CONTROL_STATUS = {2'h0, IDX_CONTROL_STATUS, 2'h0};
    localparam logic [11:0] ADDR_COUNT_VALUE    = {2'h0, IDX_COUNT_VALUE, 2'h0};
    localparam logic [11:0] ADDR_WATCHDOG_SVC   = {2'h0, IDX_WATCHDOG_SVC, 2'h0};
    localparam logic [11:0] ADDR_POWER_MODE     = {2'h0, IDX_POWER_MODE, 2'h0};

    // -------------------------------------------------------------------
    // Control/status, watchdog service and power mode field positions
    // -------------------------------------------------------------------
    localparam int BIT_WRAP_FLAG     = 7;
    localparam int BIT_PERIODIC_FLAG = 6;
    localparam int BIT_WRAP_IE       = 5;
    localparam int BIT_PERIODIC_IE   = 4;
    localparam int BIT_RATE_HI       = 1;
    localparam int BIT_RATE_LO       = 0;
    localparam int BIT_SVC           = 0;
    localparam int BIT_STOP          = 0;
    localparam logic [1:0] RATE_RESET = 2'h3;

    // -------------------------------------------------------------------
    // Chain layout
    // -------------------------------------------------------------------
    localparam int PRESCALE_BITS = 2;
    localparam int COUNT_BITS    = 8;
    localparam int EXT_BITS      = 4;
    localparam int PER_BITS      = 3;
    localparam int WD_BITS       = 3;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;

    typedef struct packed {
        logic [11:0] paddr;
        logic        pwrite;
        logic [31:0] pwdata;
        logic        psel;
        logic        penable;
    } ctt_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ctt_apb_rsp_t;

endpackage : ctt_pkg

/* File: core/ctt_chain.sv */
// Divider chain: prescaler, readable counter, extension, periodic and watchdog stages
`timescale 1ns/1ps
module ctt_chain #(
    parameter int PER_STAGES = ctt_pkg::PER_BITS
) (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            clear,
    input  wire logic                            wd_clear,
    input  wire logic [1:0]                      rate_sel,
    output logic      [ctt_pkg::COUNT_BITS-1:0]  count,
    output logic                                 wrap_pulse,
    output logic                                 periodic_pulse,
    output logic                                 wd_expire
);
    localparam int CHAIN_W = ctt_pkg::PRESCALE_BITS + ctt_pkg::COUNT_BITS + ctt_pkg::EXT_BITS + PER_STAGES;
    localparam int CNT_LO  = ctt_pkg::PRESCALE_BITS;
    localparam int PER_LO  = CNT_LO + ctt_pkg::COUNT_BITS + ctt_pkg::EXT_BITS - 1;

    if (PER_STAGES != ctt_pkg::PER_BITS)
    begin : g_bad_stages
        $error("ctt_chain: periodic divider must have three stages");
    end

    logic [CHAIN_W-1:0]           chain;
    logic [CHAIN_W-1:0]           next_chain;
    logic [ctt_pkg::WD_BITS-1:0]  wd;
    logic [ctt_pkg::WD_BITS-1:0]  next_wd;
    logic                         tap_prev;
    logic                         next_tap_prev;
    logic                         tap;

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    always_comb
    begin
        next_chain = clear ? '0 : chain + 1'b1;
        tap = chain[PER_LO + {30'h0, rate_sel}];
        next_tap_prev = clear ? 1'b0 : tap;
        periodic_pulse = !clear && tap && !tap_prev;
        wrap_pulse = !clear && (&chain[CNT_LO +: ctt_pkg::COUNT_BITS]) && (&chain[CNT_LO-1:0]);
        // Only the three watchdog stages are reset on service, so timeout is 7..8 periods
        next_wd = wd;
        if (clear || wd_clear)
        begin
            next_wd = '0;
        end
        else if (periodic_pulse)
        begin
            next_wd = wd + 1'b1;
        end
        wd_expire = periodic_pulse && !wd_clear && (&wd);
        count = chain[CNT_LO +: ctt_pkg::COUNT_BITS];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chain    <= '0;
            wd       <= '0;
            tap_prev <= 1'b0;
        end
        else
        begin
            chain    <= next_chain;
            wd       <= next_wd;
            tap_prev <= next_tap_prev;
        end
    end
endmodule : ctt_chain

/* File: core/ctt_tick_timer.sv */
// Top level: tick timer with periodic interrupt and watchdog, APB register slave
`timescale 1ns/1ps
module ctt_tick_timer #(
    parameter bit WATCHDOG_PRESENT = 1'b1,
    parameter int POWER_ON_DELAY   = 4064,
    parameter int STOP_DELAY       = 4064
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire ctt_pkg::ctt_apb_req_t apb_req,
    output ctt_pkg::ctt_apb_rsp_t      apb_rsp,
    input  wire logic                  ext_reset,
    input  wire logic                  irq_mask,
    input  wire logic                  wait_mode,
    input  wire logic                  stop_wake,
    output logic                       timer_irq,
    output logic                       wake_request,
    output logic                       device_reset,
    output logic                       stopped
);
    if (POWER_ON_DELAY < 1 || STOP_DELAY < 1)
    begin : g_bad_delay
        $error("ctt_tick_timer: delays must be at least one");
    end

    typedef enum logic [3:0] {
        CTT_POWERUP = 4'h1,
        CTT_RUN     = 4'h2,
        CTT_STOP    = 4'h4,
        CTT_RESTART = 4'h8
    } ctt_state_t;

    ctt_state_t  state;
    ctt_state_t  next_state;
    logic [31:0] delay;
    logic [31:0] next_delay;
    logic        wrap_flag;
    logic        next_wrap_flag;
    logic        periodic_flag;
    logic        next_periodic_flag;
    logic        wrap_irq_enable;
    logic        next_wrap_irq_enable;
    logic        periodic_irq_enable;
    logic        next_periodic_irq_enable;
    logic [1:0]  rate_sel;
    logic [1:0]  next_rate_sel;
    logic        wd_reset;
    logic        next_wd_reset;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic        slverr;
    logic        next_slverr;
    logic        chain_clear;
    logic        wd_clear;
    logic        wrap_pulse;
    logic        periodic_pulse;
    logic        wd_expire;
    logic [7:0]  count;
    logic        wr;
    logic        rd_setup;
    logic        hit;

    // -------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------
    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
        is_addr = (a == ref_a);
    endfunction : is_addr

    assign wr       = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign hit      = is_addr(apb_req.paddr, ctt_pkg::ADDR_CONTROL_STATUS)
                   || is_addr(apb_req.paddr, ctt_pkg::ADDR_COUNT_VALUE)
                   || is_addr(apb_req.paddr, ctt_pkg::ADDR_WATCHDOG_SVC)
                   || is_addr(apb_req.paddr, ctt_pkg::ADDR_POWER_MODE);

    // Watchdog clear; also forced high when the option is absent
    assign wd_clear = !WATCHDOG_PRESENT
        || (wr && is_addr(apb_req.paddr, ctt_pkg::ADDR_WATCHDOG_SVC)
            && !apb_req.pwdata[ctt_pkg::BIT_SVC]);

    // -------------------------------------------------------------------
    // Power and reset sequencer
    // -------------------------------------------------------------------
    always_comb
    begin
        next_state  = state;
        next_delay  = delay;
        chain_clear = 1'b0;
        case (state)
            CTT_POWERUP:
            begin
                // Chain counts freely during the delay, cleared at its end
                if (delay == POWER_ON_DELAY - 1)
                begin
                    chain_clear = 1'b1;
                    next_state  = CTT_RUN;
                    next_delay  = '0;
                end
                else
                begin
                    next_delay = delay + 32'h1;
                end
            end
            CTT_RUN:
            begin
                // Wait mode does not gate the chain
                chain_clear = ext_reset || wd_reset;
                if (wr && is_addr(apb_req.paddr, ctt_pkg::ADDR_POWER_MODE)
                    && apb_req.pwdata[ctt_pkg::BIT_STOP])
                begin
                    chain_clear = 1'b1;
                    next_state  = CTT_STOP;
                end
            end
            CTT_STOP:
            begin
                chain_clear = 1'b1;
                if (stop_wake || ext_reset)
                begin
                    next_state = CTT_RESTART;
                    next_delay = '0;
                end
            end
            CTT_RESTART:
            begin
                if (delay == STOP_DELAY - 1)
                begin
                    chain_clear = 1'b1;
                    next_state  = CTT_RUN;
                    next_delay  = '0;
                end
                else
                begin
                    next_delay = delay + 32'h1;
                end
            end
            default:
            begin
                next_state  = CTT_POWERUP;
                next_delay  = '0;
                chain_clear = 1'b1;
            end
        endcase
    end

    ctt_chain u_chain (
        .pclk           (pclk),
        .presetn        (presetn),
        .clear          (chain_clear),
        .wd_clear       (wd_clear),
        .rate_sel       (rate_sel),
        .count          (count),
        .wrap_pulse     (wrap_pulse),
        .periodic_pulse (periodic_pulse),
        .wd_expire      (wd_expire)
    );

    // -------------------------------------------------------------------
    // Registers and flags
    // -------------------------------------------------------------------
    always_comb
    begin
        next_wrap_flag           = wrap_flag;
        next_periodic_flag       = periodic_flag;
        next_wrap_irq_enable     = wrap_irq_enable;
        next_periodic_irq_enable = periodic_irq_enable;
        next_rate_sel            = rate_sel;
        next_rdata               = rdata;
        next_slverr              = 1'b0;
        next_wd_reset            = WATCHDOG_PRESENT && wd_expire && (state == CTT_RUN);
        if (wr && is_addr(apb_req.paddr, ctt_pkg::ADDR_CONTROL_STATUS))
        begin
            if (!apb_req.pwdata[ctt_pkg::BIT_WRAP_FLAG])
            begin
                next_wrap_flag = 1'b0;
            end
            if (!apb_req.pwdata[ctt_pkg::BIT_PERIODIC_FLAG])
            begin
                next_periodic_flag = 1'b0;
            end
            next_wrap_irq_enable     = apb_req.pwdata[ctt_pkg::BIT_WRAP_IE];
            next_periodic_irq_enable = apb_req.pwdata[ctt_pkg::BIT_PERIODIC_IE];
            // Changing taps mid-count may drop or add a periodic event
            next_rate_sel = {apb_req.pwdata[ctt_pkg::BIT_RATE_HI],
                             apb_req.pwdata[ctt_pkg::BIT_RATE_LO]};
        end
        // Set wins over a same-cycle clear
        if (wrap_pulse)
        begin
            next_wrap_flag = 1'b1;
        end
        if (periodic_pulse)
        begin
            next_periodic_flag = 1'b1;
        end
        if (rd_setup)
        begin
            next_rdata = '0;
            if (is_addr(apb_req.paddr, ctt_pkg::ADDR_CONTROL_STATUS))
            begin
                next_rdata[ctt_pkg::BIT_WRAP_FLAG]     = wrap_flag;
                next_rdata[ctt_pkg::BIT_PERIODIC_FLAG] = periodic_flag;
                next_rdata[ctt_pkg::BIT_WRAP_IE]       = wrap_irq_enable;
                next_rdata[ctt_pkg::BIT_PERIODIC_IE]   = periodic_irq_enable;
                next_rdata[ctt_pkg::BIT_RATE_HI]       = rate_sel[1];
                next_rdata[ctt_pkg::BIT_RATE_LO]       = rate_sel[0];
            end
            else if (is_addr(apb_req.paddr, ctt_pkg::ADDR_COUNT_VALUE))
            begin
                next_rdata[7:0] = count;
            end
            else if (is_addr(apb_req.paddr, ctt_pkg::ADDR_POWER_MODE))
            begin
                next_rdata[ctt_pkg::BIT_STOP] = (state == CTT_STOP);
            end
        end
        if (apb_req.psel && !apb_req.penable)
        begin
            next_slverr = !hit;
            // Refused accesses, writes too, must not show stale read data
            if (!hit)
            begin
                next_rdata = '0;
            end
        end
        // Reset sources return control to defaults
        if (ext_reset || wd_reset || state == CTT_POWERUP)
        begin
            next_wrap_flag           = 1'b0;
            next_periodic_flag       = 1'b0;
            next_wrap_irq_enable     = 1'b0;
            next_periodic_irq_enable = 1'b0;
            next_rate_sel            = ctt_pkg::RATE_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state               <= CTT_POWERUP;
            delay               <= '0;
            wrap_flag           <= 1'b0;
            periodic_flag       <= 1'b0;
            wrap_irq_enable     <= 1'b0;
            periodic_irq_enable <= 1'b0;
            rate_sel            <= ctt_pkg::RATE_RESET;
            wd_reset            <= 1'b0;
            rdata               <= '0;
            slverr              <= 1'b0;
        end
        else
        begin
            state               <= next_state;
            delay               <= next_delay;
            wrap_flag           <= next_wrap_flag;
            periodic_flag       <= next_periodic_flag;
            wrap_irq_enable     <= next_wrap_irq_enable;
            periodic_irq_enable <= next_periodic_irq_enable;
            rate_sel            <= next_rate_sel;
            wd_reset            <= next_wd_reset;
            rdata               <= next_rdata;
            slverr              <= next_slverr;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign wake_request = (wrap_flag && wrap_irq_enable)
                       || (periodic_flag && periodic_irq_enable);
    assign timer_irq    = wake_request && !irq_mask;
    assign device_reset = wd_reset || state == CTT_POWERUP || ext_reset;
    assign stopped      = (state == CTT_STOP);
    // Zero wait states: every access completes in its first access cycle
    assign apb_rsp = '{prdata:  rdata,
                       pready:  1'b1,
                       pslverr: slverr && apb_req.psel && apb_req.penable};
endmodule : ctt_tick_timer

/* File: verif/ctt_tick_timer_monitor.sv */
// Checker: port-level properties of the tick timer
`timescale 1ns/1ps
module ctt_tick_timer_monitor #(
    parameter bit WATCHDOG_PRESENT = 1'b1,
    parameter int POWER_ON_DELAY   = 4064,
    parameter int STOP_DELAY       = 4064
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire ctt_pkg::ctt_apb_req_t apb_req,
    input wire ctt_pkg::ctt_apb_rsp_t apb_rsp,
    input wire logic                  ext_reset,
    input wire logic                  irq_mask,
    input wire logic                  stop_wake,
    input wire logic                  timer_irq,
    input wire logic                  wake_request,
    input wire logic                  device_reset,
    input wire logic                  stopped
);
    logic acc;
    logic mapped;
    assign acc = apb_req.psel && apb_req.penable;
    assign mapped = apb_req.paddr inside {ctt_pkg::ADDR_CONTROL_STATUS, ctt_pkg::ADDR_COUNT_VALUE,
                                          ctt_pkg::ADDR_WATCHDOG_SVC, ctt_pkg::ADDR_POWER_MODE};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_mask_blocks_irq: assert property (irq_mask |-> !timer_irq)
        else $error("timer irq raised while masked");
    a_irq_wakes_cpu: assert property (timer_irq |-> wake_request)
        else $error("irq without wake request");
    a_ext_holds_reset: assert property (ext_reset |-> ##[0:1] device_reset)
        else $error("external reset not passed on");
    a_ext_clears_irq: assert property (ext_reset |-> ##[1:2] !timer_irq)
        else $error("irq survives external reset");
    a_unmapped_err: assert property (acc && !mapped |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (acc && mapped |-> !apb_rsp.pslverr)
        else $error("mapped access refused");
    a_unused_zero: assert property (acc && !apb_req.pwrite
        && apb_req.paddr == ctt_pkg::ADDR_CONTROL_STATUS
        |-> apb_rsp.prdata[31:8] == 24'h0 && apb_rsp.prdata[3:2] == 2'h0)
        else $error("unused control bits not zero");
    a_power_on_hold: assert property ($rose(presetn) |-> device_reset [*6] ##[1:20] !device_reset)
        else $error("power-on delay wrong");
    a_stop_holds: assert property (stopped && !stop_wake && !ext_reset |=> stopped)
        else $error("stop left without wake");
    a_ready_high: assert property (acc |-> apb_rsp.pready)
        else $error("access phase without ready");
endmodule : ctt_tick_timer_monitor

bind ctt_tick_timer ctt_tick_timer_monitor #(.WATCHDOG_PRESENT(WATCHDOG_PRESENT), .POWER_ON_DELAY(POWER_ON_DELAY),
    .STOP_DELAY(STOP_DELAY)) mon_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ext_reset(ext_reset), .irq_mask(irq_mask), .stop_wake(stop_wake), .timer_irq(timer_irq),
    .wake_request(wake_request), .device_reset(device_reset), .stopped(stopped));

/* File: verif/ctt_tick_timer_bench.sv */
// Self-checking bench for the tick timer
`timescale 1ns/1ps
module ctt_tick_timer_bench;
    localparam int LIMIT = 60000;
    localparam logic [11:0] CS = ctt_pkg::ADDR_CONTROL_STATUS;
    localparam logic [11:0] CV = ctt_pkg::ADDR_COUNT_VALUE;
    typedef struct packed {
        logic [11:0] addr;
        logic        wr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic        err;
    } ctt_row_t;
    logic                  pclk;
    logic                  presetn;
    ctt_pkg::ctt_apb_req_t apb_req;
    ctt_pkg::ctt_apb_rsp_t apb_rsp;
    logic                  ext_reset;
    logic                  irq_mask;
    logic                  wait_mode;
    logic                  stop_wake;
    logic                  timer_irq;
    logic                  wake_request;
    logic                  device_reset;
    logic                  stopped;
    int                    miscompares = 0;
    int                    check_count = 0;
    int                    cyc = 0;
    int                    c1;
    int                    c2;
    logic [31:0]           rd;
    logic [31:0]           rd2;
    logic                  er;
    ctt_row_t              rows [12];

    ctt_tick_timer #(.WATCHDOG_PRESENT(1'b1), .POWER_ON_DELAY(8), .STOP_DELAY(8)) dut_u (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .ext_reset(ext_reset),
        .irq_mask(irq_mask), .wait_mode(wait_mode), .stop_wake(stop_wake), .timer_irq(timer_irq),
        .wake_request(wake_request), .device_reset(device_reset), .stopped(stopped));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge pclk);
        apb_req <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        // Only the bench timeout ends a wait for the answer
        do
        begin
            @(posedge pclk);
        end
        while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    // Bounded waits; an expiry shows up as a failed compare
    task automatic wait_irq(output int at);
        int n;
        for (n = 0; n < 20000 && timer_irq !== 1'b1; n++)
            @(posedge pclk);
        at = cyc;
    endtask : wait_irq

    task automatic wait_run;
        int n;
        for (n = 0; n < 200 && (device_reset !== 1'b0 || stopped !== 1'b0); n++)
            @(posedge pclk);
        chk({31'h0, device_reset}, 32'h0);
    endtask : wait_run

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            miscompares++;
            end_sim();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        apb_req = '0;
        ext_reset = 1'b0;
        irq_mask = 1'b0;
        wait_mode = 1'b0;
        stop_wake = 1'b0;
        rows = '{'{CS, 1'b0, 32'h0, 32'h03, 1'b0}, '{CS, 1'b1, 32'hff, 32'h0, 1'b0},
                 '{CS, 1'b0, 32'h0, 32'h33, 1'b0}, '{CS, 1'b1, 32'h12, 32'h0, 1'b0},
                 '{CS, 1'b0, 32'h0, 32'h12, 1'b0}, '{CS, 1'b1, 32'h21, 32'h0, 1'b0},
                 '{CS, 1'b0, 32'h0, 32'h21, 1'b0}, '{CS, 1'b1, 32'h00, 32'h0, 1'b0},
                 '{CS, 1'b0, 32'h0, 32'h00, 1'b0}, '{12'h100, 1'b1, 32'h5a, 32'h0, 1'b1},
                 '{12'h100, 1'b0, 32'h0, 32'h0, 1'b1}, '{CS, 1'b1, 32'h23, 32'h0, 1'b0}};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(posedge pclk);
        chk({31'h0, device_reset}, 32'h1);
        wait_run();
        foreach (rows[i])
        begin
            apb(rows[i].addr, rows[i].wr, rows[i].wdata, rd, er);
            if (!rows[i].wr)
                chk(rd, rows[i].exp);
            chk({31'h0, er}, {31'h0, rows[i].err});
        end
        // Count moves by one every four clocks and ignores writes
        apb(CV, 1'b0, 32'h0, rd, er);
        apb(CV, 1'b1, 32'hff, rd2, er);
        repeat (2) @(posedge pclk);
        apb(CV, 1'b0, 32'h0, rd2, er);
        chk({24'h0, rd2[7:0] - rd[7:0]}, 32'h2);
        // Wrap flag: period, masking, write-one and write-zero
        wait_mode <= 1'b1;
        wait_irq(c1);
        irq_mask <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({30'h0, timer_irq, wake_request}, 32'h1);
        irq_mask <= 1'b0;
        apb(CS, 1'b1, 32'ha3, rd, er);
        apb(CS, 1'b0, 32'h0, rd, er);
        chk(rd, 32'ha3);
        apb(CS, 1'b1, 32'h23, rd, er);
        apb(CS, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h23);
        wait_irq(c2);
        chk(c2 - c1, 32'd1024);
        wait_mode <= 1'b0;
        // External reset restores control defaults
        ext_reset <= 1'b1;
        repeat (3) @(posedge pclk);
        ext_reset <= 1'b0;
        wait_run();
        apb(CS, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h03);
        // Stop mode: chain restarts from zero after wake
        apb(ctt_pkg::ADDR_POWER_MODE, 1'b1, 32'h1, rd, er);
        @(posedge pclk);
        chk({31'h0, stopped}, 32'h1);
        stop_wake <= 1'b1;
        @(posedge pclk);
        stop_wake <= 1'b0;
        wait_run();
        // Eight-cycle restart delay ends in a clear; ten clocks later the count reads two
        repeat (16) @(posedge pclk);
        apb(CV, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h2);
        // Periodic flag at the fastest rate; watchdog serviced first
        apb(ctt_pkg::ADDR_WATCHDOG_SVC, 1'b1, 32'h0, rd, er);
        apb(CS, 1'b1, 32'h10, rd, er);
        wait_irq(c1);
        apb(CS, 1'b1, 32'h10, rd, er);
        apb(ctt_pkg::ADDR_WATCHDOG_SVC, 1'b1, 32'h0, rd, er);
        wait_irq(c2);
        chk(c2 - c1, 32'd16384);
        chk({31'h0, device_reset}, 32'h0);
        end_sim();
    end
endmodule : ctt_tick_timer_bench
